// ===== include/pmb_pkg.sv
/*
  package for the power management register bank: register addresses, bit positions, reset values.
  assumes an 8-bit special-function-register bus with 8-bit addresses.
*/
package pmb_pkg;
  localparam logic [7:0] ADDR_PM_IRQ_ENABLE  = 8'hec;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_STATUS_CFG     = 8'hf4;
  localparam logic [7:0] ADDR_SWITCHOVER_CFG = 8'hf5;
  localparam logic [7:0] ADDR_PM_IRQ_FLAGS   = 8'hf8;
  localparam logic [7:0] ADDR_SCRATCH_A      = 8'hfb;
  localparam logic [7:0] ADDR_SCRATCH_B      = 8'hfc;
  localparam logic [7:0] ADDR_INT_PIN_CFG    = 8'hff;
  localparam logic [7:0] ADDR_UNLOCK_KEY     = 8'hc1;
  localparam logic [7:0] ADDR_ADC_START      = 8'hd8;
  localparam logic [7:0] UNLOCK_VALUE        = 8'hea;
  // flag bit positions, bit address minus base address
  localparam int BIT_SUPPLY_RESTORED = 7;
  localparam int BIT_SUMMARY         = 6;
  localparam int BIT_LINE_SAG        = 5;
  localparam int BIT_DCIN_CONV       = 3;
  localparam int BIT_BATTERY         = 2;
  localparam int BIT_SWITCHOVER      = 1;
  localparam int BIT_DCIN_LOW        = 0;
  // peripheral register fields, and the pll acknowledge bit of the adc start register
  localparam int BIT_RX_WAKE     = 7;
  localparam int BIT_SRC_IND     = 6;
  localparam int BIT_SUPPLY_OK   = 5;
  localparam int BIT_PLL_FAULT   = 4;
  localparam int BIT_LP_REF      = 3;
  localparam int BIT_PLL_ACK     = 7;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] ENABLE_MASK    = 8'haf;
  localparam logic [7:0] KEY_RESET      = 8'h00;
  localparam logic [7:0] INT_PIN_RESET  = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [1:0] SWMODE_RESET   = 2'h0;
  localparam logic [1:0] RXFUNC_RESET   = 2'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmb_sfr_req_t;

  // raw event and status inputs from analog / measurement side
  typedef struct packed {
    logic on_main;
    logic main_ok;
    logic sag;
    logic dcin_event;
    logic bat_event;
    logic dcin_low;
    logic pll_unlock;
    logic rx_wake;
  } pmb_pm_in_t;
endpackage

// ===== hw/pmb_bank.sv
/*
  power management special-function register bank: flags, enables, switchover mode, peripheral status,
  key-protected interrupt pin configuration and retained scratch pads.
  assumes the core's sfr bus gives single-cycle read and write strobes on sys_clk_i, and that status
  inputs come from other clock domains and are synchronised here.
*/
// Operation
// R01 - interrupt pin config accepts a write only directly after key register holds 0xea
// R02 - software should return the key register to zero after the protected write
// R03 - an unkeyed write to the interrupt pin config leaves it unchanged
// R04 - supply restored flag sets when source goes battery to main; resets 0
// R05 - summary flag sets when any enabled power management condition occurs
// R06 - line sag flag sets on sag report from measurement engine
// R07 - dc-input conversion flag sets on threshold change or new measurement
// R08 - battery flag sets on low battery or battery measurement ready
// R09 - switchover flag sets when supply moves from main to battery
// R10 - dc-input low flag sets when dc input falls below 1.2 V
// R11 - software keeps reserved flag, enable bit 4, upper switchover bits zero
// R12 - switchover mode: 00 low main, 01 main or dcin, 1x disabled; reset 00
// R13 - peripheral bit 7 shows receive edge woke deepest sleep mode
// R14 - peripheral bit 6 shows supply source, 1 main; resets 1
// R15 - peripheral bit 5 shows main supply good; resets 1
// R16 - pll fault bit sets on lock loss, clears only on pll acknowledge write
// R17 - peripheral bit 3 keeps reference on in deepest sleep mode
// R18 - receive pin function: 00 gpio, 01 receive, 11 receive with wake
// R19 - enable bits 7,5,3,2,1,0 gate the six flags into the summary; reset 0
// R20 - scratch registers read/write, retained, reset 0
`timescale 1ns/100ps
module pmb_bank (
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire pmb_pkg::pmb_sfr_req_t sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire pmb_pkg::pmb_pm_in_t   pm_in_i,
  output logic                       switchover_on_main_low_o,
  output logic                       switchover_on_dcin_low_o,
  output logic                       lowpower_ref_enable_o,
  output logic [1:0]                 rx_pin_function_o,
  output logic                       rx_wake_enable_o,
  output logic [7:0]                 int_pin_config_o,
  output logic                       pm_irq_o
);
  import pmb_pkg::*;

  // two-stage synchroniser per status bit
  pmb_pm_in_t sync1_reg;
  pmb_pm_in_t sync2_reg;
  pmb_pm_in_t prev_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '{on_main: 1'b1, main_ok: 1'b1, default: 1'b0};
      sync2_reg <= '{on_main: 1'b1, main_ok: 1'b1, default: 1'b0};
      prev_reg  <= '{on_main: 1'b1, main_ok: 1'b1, default: 1'b0};
    end else begin
      sync1_reg <= pm_in_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic wr_key, wr_int, wr_en, wr_flags, wr_sw, wr_per, wr_sa, wr_sb, wr_adc;
  assign wr_key   = sfr_req_i.wr && (sfr_req_i.addr == ADDR_UNLOCK_KEY);
  assign wr_int   = sfr_req_i.wr && (sfr_req_i.addr == ADDR_INT_PIN_CFG);
  assign wr_en    = sfr_req_i.wr && (sfr_req_i.addr == ADDR_PM_IRQ_ENABLE);
  assign wr_flags = sfr_req_i.wr && (sfr_req_i.addr == ADDR_PM_IRQ_FLAGS);
  assign wr_sw    = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SWITCHOVER_CFG);
  assign wr_per   = sfr_req_i.wr && (sfr_req_i.addr == ADDR_PERIPHERAL_CONFIG_STATUS_CFG);
  assign wr_sa    = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SCRATCH_A);
  assign wr_sb    = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SCRATCH_B);
  assign wr_adc   = sfr_req_i.wr && (sfr_req_i.addr == ADDR_ADC_START);

  // raw events, one-cycle pulses
  logic [7:0] evt;
  always_comb begin
    evt = 8'h00;
    evt[BIT_SUPPLY_RESTORED] = sync2_reg.on_main && !prev_reg.on_main; // R04
    evt[BIT_LINE_SAG]        = sync2_reg.sag && !prev_reg.sag; // R06
    evt[BIT_DCIN_CONV]       = sync2_reg.dcin_event && !prev_reg.dcin_event; // R07
    evt[BIT_BATTERY]         = sync2_reg.bat_event && !prev_reg.bat_event; // R08
    evt[BIT_SWITCHOVER]      = !sync2_reg.on_main && prev_reg.on_main; // R09
    evt[BIT_DCIN_LOW]        = sync2_reg.dcin_low && !prev_reg.dcin_low; // R10
  end

  logic [7:0] key_reg, key_next;
  logic       armed_reg, armed_next;
  logic [7:0] int_reg, int_next;
  logic [7:0] en_reg, en_next;
  logic [7:0] flags_reg, flags_next;
  logic [1:0] swmode_reg, swmode_next;
  logic       pllf_reg, pllf_next;
  logic       lpref_reg, lpref_next;
  logic [1:0] rxf_reg, rxf_next;
  logic [7:0] sa_reg, sa_next;
  logic [7:0] sb_reg, sb_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] peripheral_config_status_view;

  assign peripheral_config_status_view = {sync2_reg.rx_wake, sync2_reg.on_main, sync2_reg.main_ok, // R13 R14 R15
                        pllf_reg, lpref_reg, 1'b0, rxf_reg};

  always_comb begin
    key_next    = key_reg;
    int_next    = int_reg;
    en_next     = en_reg;
    flags_next  = flags_reg;
    swmode_next = swmode_reg;
    pllf_next   = pllf_reg;
    lpref_next  = lpref_reg;
    rxf_next    = rxf_reg;
    sa_next     = sa_reg;
    sb_next     = sb_reg;
    // unlock lasts only for the write straight after the key write
    armed_next  = sfr_req_i.wr ? (wr_key && sfr_req_i.wdata == UNLOCK_VALUE) : armed_reg; // R01
    if (wr_key) begin
      key_next = sfr_req_i.wdata; // R02
    end
    if (wr_int && armed_reg) begin
      int_next = sfr_req_i.wdata; // R01 R03
    end
    if (wr_en) begin
      en_next = sfr_req_i.wdata & ENABLE_MASK; // R19 R11
    end
    if (wr_sw) begin
      swmode_next = sfr_req_i.wdata[1:0]; // R12
    end
    if (wr_per) begin
      lpref_next = sfr_req_i.wdata[BIT_LP_REF]; // R17
      rxf_next   = sfr_req_i.wdata[1:0]; // R18
    end
    if (wr_sa) begin
      sa_next = sfr_req_i.wdata; // R20
    end
    if (wr_sb) begin
      sb_next = sfr_req_i.wdata; // R20
    end
    if (wr_adc && sfr_req_i.wdata[BIT_PLL_ACK]) begin
      pllf_next = 1'b0; // R16
    end
    if (sync2_reg.pll_unlock && !prev_reg.pll_unlock) begin
      pllf_next = 1'b1; // R16
    end
    if (wr_flags) begin
      flags_next = sfr_req_i.wdata & ENABLE_MASK | (sfr_req_i.wdata & 8'h40);
    end
    // set wins over a write clearing in the same cycle
    flags_next = flags_next | evt; // R04 R06 R07 R08 R09 R10
    if (|(evt & en_reg)) begin
      flags_next[BIT_SUMMARY] = 1'b1; // R05 R19
    end
    case (sfr_req_i.addr)
      ADDR_PM_IRQ_ENABLE:  rdata_next = en_reg;
      ADDR_PERIPHERAL_CONFIG_STATUS_CFG:     rdata_next = peripheral_config_status_view;
      ADDR_SWITCHOVER_CFG: rdata_next = {6'h00, swmode_reg};
      ADDR_PM_IRQ_FLAGS:   rdata_next = flags_reg;
      ADDR_SCRATCH_A:      rdata_next = sa_reg;
      ADDR_SCRATCH_B:      rdata_next = sb_reg;
      ADDR_INT_PIN_CFG:    rdata_next = int_reg;
      ADDR_UNLOCK_KEY:     rdata_next = key_reg;
      default:             rdata_next = 8'h00;
    endcase
    if (!sfr_req_i.rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_reg    <= KEY_RESET;
      armed_reg  <= 1'b0;
      int_reg    <= INT_PIN_RESET;
      en_reg     <= ENABLE_RESET;
      flags_reg  <= FLAGS_RESET;
      swmode_reg <= SWMODE_RESET;
      pllf_reg   <= 1'b0;
      lpref_reg  <= 1'b0;
      rxf_reg    <= RXFUNC_RESET;
      sa_reg     <= SCRATCH_RESET;
      sb_reg     <= SCRATCH_RESET;
      rdata_reg  <= 8'h00;
    end else begin
      key_reg    <= key_next;
      armed_reg  <= armed_next;
      int_reg    <= int_next;
      en_reg     <= en_next;
      flags_reg  <= flags_next;
      swmode_reg <= swmode_next;
      pllf_reg   <= pllf_next;
      lpref_reg  <= lpref_next;
      rxf_reg    <= rxf_next;
      sa_reg     <= sa_next;
      sb_reg     <= sb_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign sfr_rdata_o              = rdata_reg;
  assign switchover_on_main_low_o = !swmode_reg[1]; // R12
  assign switchover_on_dcin_low_o = (swmode_reg == 2'h1); // R12
  assign lowpower_ref_enable_o    = lpref_reg; // R17
  assign rx_pin_function_o        = rxf_reg; // R18
  assign rx_wake_enable_o         = (rxf_reg == 2'h3); // R18
  assign int_pin_config_o         = int_reg;
  assign pm_irq_o                 = flags_reg[BIT_SUMMARY];

  chk_unkeyed_write: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R03
    (wr_int && !armed_reg) |=> $stable(int_reg)) else $error("unkeyed write changed pin config");
  chk_keyed_write: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R01
    (wr_key && sfr_req_i.wdata == UNLOCK_VALUE) ##1 (wr_int) |=> int_reg == $past(sfr_req_i.wdata))
    else $error("keyed write not taken");
  chk_restored_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R04
    (sync2_reg.on_main && !prev_reg.on_main) |=> flags_reg[BIT_SUPPLY_RESTORED]) else $error("restored flag missed");
  chk_switch_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R09
    $fell(sync2_reg.on_main) |=> flags_reg[BIT_SWITCHOVER]) else $error("switchover flag missed");
  chk_summary_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R05
    (|(evt & en_reg)) |=> flags_reg[BIT_SUMMARY]) else $error("summary flag missed");
  chk_summary_gate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R19
    (!(|(evt & en_reg)) && !wr_flags && !flags_reg[BIT_SUMMARY]) |=> !flags_reg[BIT_SUMMARY])
    else $error("summary set without enable");
  chk_pll_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R16
    (pllf_reg && !(wr_adc && sfr_req_i.wdata[BIT_PLL_ACK])) |=> pllf_reg) else $error("pll fault cleared early");
  chk_scratch_keep: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R20
    (!wr_sa) |=> $stable(sa_reg)) else $error("scratch changed without write");
  chk_mode_out: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R12
    swmode_reg[1] |-> !switchover_on_main_low_o && !switchover_on_dcin_low_o) else $error("mode 1x not off");

  // remaining event flags follow their synchronised edges
  chk_sag_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R06
    evt[BIT_LINE_SAG] |=> flags_reg[BIT_LINE_SAG])
    else $error("sag flag missed");

  chk_dcin_conv_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R07
    evt[BIT_DCIN_CONV] |=> flags_reg[BIT_DCIN_CONV])
    else $error("dc-input conversion flag missed");

  chk_battery_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R08
    evt[BIT_BATTERY] |=> flags_reg[BIT_BATTERY])
    else $error("battery flag missed");

  chk_dcin_low_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R10
    evt[BIT_DCIN_LOW] |=> flags_reg[BIT_DCIN_LOW])
    else $error("dc-input low flag missed");

  chk_flag_reserved: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R11
    flags_reg[4] == 1'b0)
    else $error("reserved flag bit set");

  chk_enable_reserved: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R19
    (en_reg & ~ENABLE_MASK) == 8'h00)
    else $error("reserved enable bit set");

  // pll fault sets on lock loss, clears on acknowledge when no new loss arrives
  chk_pll_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R16
    (sync2_reg.pll_unlock && !prev_reg.pll_unlock) |=> pllf_reg)
    else $error("pll fault not set");

  chk_pll_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R16
    (wr_adc && sfr_req_i.wdata[BIT_PLL_ACK] && !(sync2_reg.pll_unlock && !prev_reg.pll_unlock)) |=> !pllf_reg)
    else $error("pll fault not cleared");

  // status bits as software reads them
  chk_wake_view: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R13
    (sfr_req_i.rd && sfr_req_i.addr == ADDR_PERIPHERAL_CONFIG_STATUS_CFG) |=> sfr_rdata_o[BIT_RX_WAKE] == $past(sync2_reg.rx_wake))
    else $error("wake event bit wrong");

  chk_source_view: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R14
    (sfr_req_i.rd && sfr_req_i.addr == ADDR_PERIPHERAL_CONFIG_STATUS_CFG) |=> sfr_rdata_o[BIT_SRC_IND] == $past(sync2_reg.on_main))
    else $error("supply source bit wrong");

  chk_supply_ok_view: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R15
    (sfr_req_i.rd && sfr_req_i.addr == ADDR_PERIPHERAL_CONFIG_STATUS_CFG) |=> sfr_rdata_o[BIT_SUPPLY_OK] == $past(sync2_reg.main_ok))
    else $error("supply good bit wrong");

  chk_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R20
    !sfr_req_i.rd |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");

  chk_scratch_b_keep: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R20
    (!wr_sb) |=> $stable(sb_reg))
    else $error("scratch b changed without write");

  chk_key_disarm: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R03
    (sfr_req_i.wr && !wr_key) |=> !armed_reg)
    else $error("unlock survived another write");

  chk_wake_out: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R18
    (wr_per && sfr_req_i.wdata[1:0] == 2'h3) |=> rx_wake_enable_o)
    else $error("receive wake not enabled");

  chk_mode_dcin: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R12
    (swmode_reg == 2'h1) |-> switchover_on_dcin_low_o)
    else $error("mode 01 lacks dc-input trigger");

  chk_mode_main: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R12
    (swmode_reg[1] == 1'b0) |-> switchover_on_main_low_o)
    else $error("low main trigger missing");

  cov_keyed: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) armed_reg ##0 wr_int);
  cov_summary: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(pm_irq_o));
  cov_pll_ack: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $fell(pllf_reg));
  cov_unkeyed: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) wr_int && !armed_reg);
  cov_switchover: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(flags_reg[BIT_SWITCHOVER]));
endmodule

// ===== testbench/pmb_bank_tb.sv
/*
  self-checking bench for the power management register bank: register table, key lock, flags, outputs.
  assumes the design package is compiled first; the bench drives all ports on the falling clock edge.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module pmb_bank_tb;
  import pmb_pkg::*;
  typedef struct packed { logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; } pmb_row_t;
  logic          sys_clk_i = 1'b0;
  logic          arst_n_i  = 1'b0;
  pmb_sfr_req_t  sfr_req_i = '0;
  pmb_pm_in_t    pm_in_i   = pmb_pm_in_t'(8'hc0);
  logic [7:0]    sfr_rdata_o, int_pin_config_o;
  logic [1:0]    rx_pin_function_o;
  logic          sw_main_o, sw_dcin_o, lp_ref_o, rx_wake_en_o, pm_irq_o;
  int            num_errors = 0;
  int            comparisons = 0;
  pmb_row_t      rows [8];
  logic [7:0]    ev_mask [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h80};
  logic [7:0]    ev_flag [5] = '{8'h20, 8'h08, 8'h04, 8'h01, 8'h02};
  logic [1:0]    rx_f [3] = '{2'h0, 2'h1, 2'h3};

  always #2.5 sys_clk_i = ~sys_clk_i;

  pmb_bank i_pmb_bank (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
    .pm_in_i(pm_in_i), .switchover_on_main_low_o(sw_main_o), .switchover_on_dcin_low_o(sw_dcin_o),
    .lowpower_ref_enable_o(lp_ref_o), .rx_pin_function_o(rx_pin_function_o),
    .rx_wake_enable_o(rx_wake_en_o), .int_pin_config_o(int_pin_config_o), .pm_irq_o(pm_irq_o)
  );

  // one strobe cycle; read data is settled at the falling edge after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i) sfr_req_i = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge sys_clk_i) sfr_req_i = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    acc(1'b0, a, 8'h00);
    `CHK("read data", ex, sfr_rdata_o)
  endtask

  task automatic settle();
    repeat (5) @(negedge sys_clk_i);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    close_out();
  end

  initial begin
    rows[0] = '{ADDR_PM_IRQ_ENABLE, 8'hff, 8'haf};
    rows[1] = '{ADDR_SWITCHOVER_CFG, 8'hff, 8'h03};
    rows[2] = '{ADDR_SCRATCH_A, 8'h5a, 8'h5a};
    rows[3] = '{ADDR_SCRATCH_B, 8'ha5, 8'ha5};
    rows[4] = '{ADDR_PM_IRQ_FLAGS, 8'h10, 8'h00};
    rows[5] = '{ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h0b, 8'h6b};
    rows[6] = '{8'h80, 8'h12, 8'h00};
    rows[7] = '{ADDR_PM_IRQ_ENABLE, 8'h00, 8'h00};
    repeat (12) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    `CHK("main low switchover", 1'b1, sw_main_o)
    rd(ADDR_PM_IRQ_ENABLE, 8'h00);
    rd(ADDR_SWITCHOVER_CFG, 8'h00);
    rd(ADDR_PM_IRQ_FLAGS, 8'h00);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h60);
    rd(ADDR_SCRATCH_A, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      acc(1'b1, rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    $display("test table done");
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, ADDR_SWITCHOVER_CFG, 8'(m));
      `CHK("main low switchover", m < 2, sw_main_o)
      `CHK("dcin low switchover", m == 1, sw_dcin_o)
    end
    foreach (rx_f[i]) begin
      acc(1'b1, ADDR_PERIPHERAL_CONFIG_STATUS_CFG, {6'h02, rx_f[i]});
      `CHK("lowpower ref", 1'b1, lp_ref_o)
      `CHK("rx function", rx_f[i], rx_pin_function_o)
      `CHK("rx wake enable", rx_f[i] == 2'h3, rx_wake_en_o)
    end
    $display("test outputs done");
    acc(1'b1, ADDR_INT_PIN_CFG, 8'h33);
    `CHK("int pin config", 8'h00, int_pin_config_o)
    acc(1'b1, ADDR_UNLOCK_KEY, UNLOCK_VALUE);
    acc(1'b1, ADDR_SCRATCH_A, 8'h01);
    acc(1'b1, ADDR_INT_PIN_CFG, 8'h44);
    `CHK("int pin config", 8'h00, int_pin_config_o)
    acc(1'b1, ADDR_UNLOCK_KEY, UNLOCK_VALUE);
    acc(1'b1, ADDR_INT_PIN_CFG, 8'h80);
    `CHK("int pin config", 8'h80, int_pin_config_o)
    acc(1'b1, ADDR_UNLOCK_KEY, 8'h00);
    acc(1'b1, ADDR_INT_PIN_CFG, 8'h11);
    `CHK("int pin config", 8'h80, int_pin_config_o)
    $display("test key lock done");
    foreach (ev_mask[i]) begin
      pm_in_i = pmb_pm_in_t'(8'hc0 ^ ev_mask[i]);
      settle();
      rd(ADDR_PM_IRQ_FLAGS, ev_flag[i]);
      `CHK("irq disabled", 1'b0, pm_irq_o)
      pm_in_i = pmb_pm_in_t'(8'hc0);
      settle();
      acc(1'b1, ADDR_PM_IRQ_FLAGS, 8'h00);
    end
    rd(ADDR_PM_IRQ_FLAGS, 8'h00);
    pm_in_i = pmb_pm_in_t'(8'h40);
    settle();
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h2b);
    pm_in_i = pmb_pm_in_t'(8'hc0);
    settle();
    rd(ADDR_PM_IRQ_FLAGS, 8'h82);
    acc(1'b1, ADDR_PM_IRQ_FLAGS, 8'h00);
    acc(1'b1, ADDR_PM_IRQ_ENABLE, 8'h20);
    pm_in_i = pmb_pm_in_t'(8'he0);
    settle();
    rd(ADDR_PM_IRQ_FLAGS, 8'h60);
    `CHK("irq out", 1'b1, pm_irq_o)
    acc(1'b1, ADDR_PM_IRQ_FLAGS, 8'h00);
    `CHK("irq out", 1'b0, pm_irq_o)
    acc(1'b1, ADDR_PM_IRQ_ENABLE, 8'h02);
    pm_in_i = pmb_pm_in_t'(8'h00);
    settle();
    rd(ADDR_PM_IRQ_FLAGS, 8'h42);
    `CHK("irq out", 1'b1, pm_irq_o)
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h0b);
    pm_in_i = pmb_pm_in_t'(8'hc0);
    settle();
    acc(1'b1, ADDR_PM_IRQ_FLAGS, 8'h00);
    $display("test flags done");
    pm_in_i = pmb_pm_in_t'(8'hc2);
    settle();
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h7b);
    acc(1'b1, ADDR_ADC_START, 8'h00);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h7b);
    acc(1'b1, ADDR_ADC_START, 8'h80);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h6b);
    pm_in_i = pmb_pm_in_t'(8'hc1);
    settle();
    rd(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'heb);
    $display("test peripheral_config_status done");
    @(negedge sys_clk_i) arst_n_i = 1'b0;
    @(negedge sys_clk_i) arst_n_i = 1'b1;
    `CHK("int pin config", 8'h00, int_pin_config_o)
    rd(ADDR_SCRATCH_B, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
